// file: ms_ctrl_regs.vh
`ifndef MS_CTRL_REGS_VH
`define MS_CTRL_REGS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define MS_OFS_CMD            5'h00
`define MS_OFS_RAST           5'h04
`define MS_OFS_STATUS         5'h08
`define MS_OFS_OFFSETS        5'h0C
`define MS_OFS_DECODE         5'h10

// ****************************************
// Command header fields
// ****************************************
`define MS_HDR_TYPE_HI        31
`define MS_HDR_TYPE_LO        29
`define MS_HDR_SUBT_HI        28
`define MS_HDR_SUBT_LO        27
`define MS_HDR_OPC_HI         26
`define MS_HDR_OPC_LO         24
`define MS_HDR_SUBOP_HI       23
`define MS_HDR_SUBOP_LO       16
`define MS_HDR_LEN_HI         7
`define MS_HDR_LEN_LO         0
`define MS_GRAPHICS_CMD_TYPE  3'h3
`define MS_GRAPHICS_3D_SUBT   2'h3
`define MS_NONPIPELINED_OPC   3'h1
`define MS_MULTISAMPLE_SUBOP  8'h0D
`define MS_LEN_THIS_VERSION   8'h01

// ****************************************
// Second dword fields
// ****************************************
`define MS_DW1_PIXLOC_BIT     4
`define MS_DW1_COUNT_HI       3
`define MS_DW1_COUNT_LO       1

// ****************************************
// Encodings
// ****************************************
`define MS_LOCATION_CENTER    1'h0
`define MS_LOCATION_UL        1'h1
`define MS_ONE_SAMPLE_CODE    3'h0
`define MS_FOUR_SAMPLES_CODE  3'h2
`define MS_RASTER_OFF_PIXEL   2'h0
`define MS_RASTER_OFF_PATTERN 2'h1
`define MS_RASTER_ON_PIXEL    2'h2
`define MS_RASTER_ON_PATTERN  2'h3
`define MS_COUNT_ONE          3'h1
`define MS_COUNT_FOUR         3'h4

// ****************************************
// Control register fields and reset values
// ****************************************
`define MS_RAST_MODE_HI       1
`define MS_RAST_MODE_LO       0
`define MS_RAST_DISPATCH_BIT  2
`define MS_RAST_RESET         2'h0
`define MS_DISPATCH_RESET     1'h1
`define MS_COUNT_CODE_RESET   3'h0
`define MS_PIXLOC_RESET       1'h0
`define MS_OFFSETS_RESET      32'h00000000
`define MS_POS_RESET          8'h00
`define MS_STATUS_CLR_BIT     5
`define MS_OFFSET_WIDTH       8
`define MS_SAMPLES            4

`endif

// file: sample_offset_store.v
`timescale 1ns/100ps
`include "ms_ctrl_regs.vh"

module sample_offset_store (
   // Clock and reset
   input  wire        i_clk_sys,
   input  wire        i_rst,
   // Load port
   input  wire        i_load,
   input  wire [31:0] i_offsets,
   // Registered read data
   output wire [31:0] o_offsets
);

   // ****************************************
   // One subpixel position per sample
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < `MS_SAMPLES; g = g + 1) begin : g_entry
         reg [`MS_OFFSET_WIDTH-1:0] pos_r;
         always @(posedge i_clk_sys) begin
            if (i_rst) begin
               pos_r <= `MS_POS_RESET;
            end else if (i_load) begin
               pos_r <= i_offsets[g*`MS_OFFSET_WIDTH +: `MS_OFFSET_WIDTH];
            end
         end
         assign o_offsets[g*`MS_OFFSET_WIDTH +: `MS_OFFSET_WIDTH] = pos_r;
      end
   endgenerate

endmodule

// file: multisample_mode_control.v
`timescale 1ns/100ps
`include "ms_ctrl_regs.vh"

module multisample_mode_control (
   // Clock and reset
   input  wire        i_clk_sys,
   input  wire        i_rst,
   // Avalon-MM slave
   input  wire [4:0]  i_address,
   input  wire        i_read,
   input  wire        i_write,
   input  wire [3:0]  i_byteenable,
   input  wire [31:0] i_writedata,
   output reg  [31:0] o_readdata,
   output reg         o_waitrequest,
   // Decoded multisample behaviour
   output reg  [2:0]  o_raster_samples,
   output reg  [2:0]  o_line_samples,
   output reg         o_nonline_at_offsets,
   output reg         o_line_at_offsets,
   output reg         o_line_legacy,
   output reg         o_line_rectangle,
   output reg         o_ps_per_sample,
   output reg         o_ps_at_offsets,
   output reg  [2:0]  o_merge_samples,
   output reg         o_depth_at_offsets,
   output reg  [2:0]  o_depth_buffer_samples,
   output reg         o_pixel_location,
   output reg  [31:0] o_sample_offsets,
   output reg         o_config_invalid,
   output reg         o_cmd_error
);

   // ****************************************
   // Parser states
   // ****************************************
   localparam [2:0] ST_HEADER = 3'b001;
   localparam [2:0] ST_DW1    = 3'b010;
   localparam [2:0] ST_DW2    = 3'b100;

   reg  [2:0]  state_r;
   reg  [2:0]  state_nxt;
   reg  [7:0]  skip_r;
   reg  [7:0]  skip_nxt;
   reg         pixloc_sh_r;
   reg  [2:0]  count_sh_r;
   reg  [31:0] offsets_sh_r;
   reg         pixloc_r;
   reg  [2:0]  count_code_r;
   reg  [1:0]  raster_mode_r;
   reg         dispatch_sample_r;
   reg         cmd_error_r;
   reg         commit;
   reg         bad_header;
   wire [31:0] offsets_q;

   wire        req     = (i_read | i_write) & o_waitrequest;
   wire        accept  = (i_read | i_write) & ~o_waitrequest;
   wire        wr_acc  = accept & i_write;
   wire        cmd_wr  = wr_acc & (i_address == `MS_OFS_CMD) & (&i_byteenable);
   wire [31:0] dw      = i_writedata;

   // ****************************************
   // Bus handshake
   // ****************************************
   // One wait state per access: read data and decode are both registered,
   // which keeps every output a flop at the cost of a cycle per access.
   always @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_waitrequest <= 1'b1;
      end else if (req) begin
         o_waitrequest <= 1'b0;
      end else begin
         o_waitrequest <= 1'b1;
      end
   end

   // ****************************************
   // Command parser
   // ****************************************
   always @* begin
      bad_header = (dw[`MS_HDR_TYPE_HI:`MS_HDR_TYPE_LO] != `MS_GRAPHICS_CMD_TYPE) |
                   (dw[`MS_HDR_SUBT_HI:`MS_HDR_SUBT_LO] != `MS_GRAPHICS_3D_SUBT) |
                   (dw[`MS_HDR_OPC_HI:`MS_HDR_OPC_LO] != `MS_NONPIPELINED_OPC) |
                   (dw[`MS_HDR_SUBOP_HI:`MS_HDR_SUBOP_LO] != `MS_MULTISAMPLE_SUBOP);
      state_nxt = state_r;
      skip_nxt  = skip_r;
      commit    = 1'b0;
      if (cmd_wr) begin
         case (state_r)
            ST_HEADER: begin
               if (skip_r != 8'h00) begin
                  skip_nxt = skip_r - 8'h01;
               end else if (bad_header) begin
                  state_nxt = ST_HEADER;
               end else if (dw[`MS_HDR_LEN_HI:`MS_HDR_LEN_LO] != `MS_LEN_THIS_VERSION) begin
                  // Unsupported length: drop the whole body, keep old state
                  skip_nxt = dw[`MS_HDR_LEN_HI:`MS_HDR_LEN_LO] + 8'h01;
               end else begin
                  state_nxt = ST_DW1;
               end
            end
            ST_DW1: begin
               state_nxt = ST_DW2;
            end
            ST_DW2: begin
               state_nxt = ST_HEADER;
               commit    = 1'b1;
            end
            default: begin
               state_nxt = ST_HEADER;
            end
         endcase
      end
   end

   always @(posedge i_clk_sys) begin
      if (i_rst) begin
         state_r     <= ST_HEADER;
         skip_r      <= 8'h00;
         cmd_error_r <= 1'b0;
         pixloc_sh_r <= `MS_PIXLOC_RESET;
         count_sh_r  <= `MS_COUNT_CODE_RESET;
         offsets_sh_r <= `MS_OFFSETS_RESET;
      end else begin
         state_r <= state_nxt;
         skip_r  <= skip_nxt;
         if (cmd_wr && (state_r == ST_HEADER) && (skip_r == 8'h00)) begin
            cmd_error_r <= bad_header |
                           (dw[`MS_HDR_LEN_HI:`MS_HDR_LEN_LO] != `MS_LEN_THIS_VERSION);
         end else if (wr_acc && (i_address == `MS_OFS_STATUS) &&
                      i_writedata[`MS_STATUS_CLR_BIT]) begin
            cmd_error_r <= 1'b0;
         end
         if (cmd_wr && (state_r == ST_DW1)) begin
            pixloc_sh_r <= dw[`MS_DW1_PIXLOC_BIT];
            count_sh_r  <= dw[`MS_DW1_COUNT_HI:`MS_DW1_COUNT_LO];
         end
         if (cmd_wr && (state_r == ST_DW2)) begin
            offsets_sh_r <= dw;
         end
      end
   end

   // ****************************************
   // Live state, committed as a whole
   // ****************************************
   // Non-pipelined state: nothing changes until the last dword arrives,
   // so the decode never sees half a command.
   always @(posedge i_clk_sys) begin
      if (i_rst) begin
         pixloc_r     <= `MS_PIXLOC_RESET;
         count_code_r <= `MS_COUNT_CODE_RESET;
      end else if (commit) begin
         pixloc_r     <= pixloc_sh_r;
         count_code_r <= count_sh_r;
      end
   end

   sample_offset_store u_offsets (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_load    (commit),
      .i_offsets (dw),
      .o_offsets (offsets_q)
   );

   // ****************************************
   // Rasterization and dispatch control
   // ****************************************
   always @(posedge i_clk_sys) begin
      if (i_rst) begin
         raster_mode_r     <= `MS_RAST_RESET;
         dispatch_sample_r <= `MS_DISPATCH_RESET;
      end else if (wr_acc && (i_address == `MS_OFS_RAST) && i_byteenable[0]) begin
         raster_mode_r     <= i_writedata[`MS_RAST_MODE_HI:`MS_RAST_MODE_LO];
         dispatch_sample_r <= i_writedata[`MS_RAST_DISPATCH_BIT];
      end
   end

   // ****************************************
   // Mode decode
   // ****************************************
   reg       d_four;
   reg       d_line_ms;
   reg       d_pattern;
   reg [2:0] d_count;
   reg       d_invalid;

   always @* begin
      d_four    = (count_code_r == `MS_FOUR_SAMPLES_CODE);
      d_count   = d_four ? `MS_COUNT_FOUR : `MS_COUNT_ONE;
      d_pattern = (raster_mode_r == `MS_RASTER_OFF_PATTERN) |
                  (raster_mode_r == `MS_RASTER_ON_PATTERN);
      d_line_ms = (raster_mode_r == `MS_RASTER_ON_PIXEL) |
                  (raster_mode_r == `MS_RASTER_ON_PATTERN);
      d_invalid = ((count_code_r != `MS_FOUR_SAMPLES_CODE) &&
                   (count_code_r != `MS_ONE_SAMPLE_CODE)) |
                  (~d_four & d_pattern) |
                  (~d_four & ~dispatch_sample_r);
   end

   always @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_raster_samples       <= `MS_COUNT_ONE;
         o_line_samples         <= `MS_COUNT_ONE;
         o_nonline_at_offsets   <= 1'b0;
         o_line_at_offsets      <= 1'b0;
         o_line_legacy          <= 1'b1;
         o_line_rectangle       <= 1'b0;
         o_ps_per_sample        <= 1'b0;
         o_ps_at_offsets        <= 1'b0;
         o_merge_samples        <= `MS_COUNT_ONE;
         o_depth_at_offsets     <= 1'b0;
         o_depth_buffer_samples <= `MS_COUNT_ONE;
         o_pixel_location       <= `MS_PIXLOC_RESET;
         o_sample_offsets       <= `MS_OFFSETS_RESET;
         o_config_invalid       <= 1'b0;
         o_cmd_error            <= 1'b0;
      end else begin
         // Pixel modes rasterize once at the location; pattern uses offsets
         o_raster_samples     <= d_pattern ? `MS_COUNT_FOUR : `MS_COUNT_ONE;
         o_nonline_at_offsets <= d_pattern;
         // Only on-pattern multisamples lines; off-pattern lines stay per pixel
         o_line_samples       <= (raster_mode_r == `MS_RASTER_ON_PATTERN) ?
                                 `MS_COUNT_FOUR : `MS_COUNT_ONE;
         o_line_at_offsets    <= (raster_mode_r == `MS_RASTER_ON_PATTERN);
         o_line_legacy        <= ~d_line_ms;
         o_line_rectangle     <= d_line_ms;
         // Per-pixel dispatch shades once at the location
         o_ps_per_sample      <= dispatch_sample_r & d_four;
         o_ps_at_offsets      <= dispatch_sample_r & d_four & d_pattern;
         o_merge_samples      <= d_count;
         o_depth_at_offsets   <= d_pattern;
         o_depth_buffer_samples <= d_count;
         o_pixel_location     <= pixloc_r;
         // Offsets only take effect in pattern modes
         o_sample_offsets     <= d_pattern ? offsets_q : `MS_OFFSETS_RESET;
         o_config_invalid     <= d_invalid;
         o_cmd_error          <= cmd_error_r;
      end
   end

   // ****************************************
   // Read data
   // ****************************************
   always @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_readdata <= 32'h00000000;
      end else if (req && i_read) begin
         case (i_address)
            `MS_OFS_RAST: begin
               o_readdata <= {29'h00000000, dispatch_sample_r, raster_mode_r};
            end
            `MS_OFS_STATUS: begin
               o_readdata <= {26'h0000000, cmd_error_r, d_invalid, count_code_r, pixloc_r};
            end
            `MS_OFS_OFFSETS: begin
               o_readdata <= offsets_q;
            end
            `MS_OFS_DECODE: begin
               o_readdata <= {19'h00000, o_depth_buffer_samples, o_merge_samples,
                              o_depth_at_offsets, o_ps_at_offsets, o_ps_per_sample,
                              o_line_rectangle, o_line_legacy, o_line_at_offsets,
                              o_nonline_at_offsets};
            end
            default: begin
               o_readdata <= 32'h00000000;
            end
         endcase
      end
   end

endmodule

// file: ms_ctrl_monitor.sv
`timescale 1ns/100ps
// ****************************************
// Port checker for the multisample control
// ****************************************
module ms_ctrl_monitor (
   input wire        i_clk_sys,
   input wire        i_rst,
   input wire [4:0]  i_address,
   input wire        i_read,
   input wire        i_write,
   input wire [31:0] o_readdata,
   input wire        o_waitrequest,
   input wire [2:0]  o_line_samples,
   input wire        o_nonline_at_offsets,
   input wire        o_line_at_offsets,
   input wire        o_line_legacy,
   input wire        o_line_rectangle,
   input wire        o_ps_per_sample,
   input wire        o_ps_at_offsets,
   input wire [2:0]  o_merge_samples,
   input wire        o_depth_at_offsets,
   input wire [2:0]  o_depth_buffer_samples,
   input wire [31:0] o_sample_offsets
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   AST_ACCEPT_NEXT: assert property (
      (i_read || i_write) && o_waitrequest |=> !o_waitrequest) else $error("no answer");
   AST_ANSWER_ONE: assert property (
      !o_waitrequest |-> $past(i_read || i_write) ##1 o_waitrequest) else $error("bad answer");
   AST_UNMAPPED_ZERO: assert property (
      i_read && o_waitrequest && i_address > 5'h10 |=> o_readdata == 32'h0)
      else $error("unmapped read not zero");
   AST_LINE_KIND: assert property (o_line_legacy != o_line_rectangle)
      else $error("line kind clash");
   AST_ON_PATTERN: assert property ($rose(o_line_at_offsets) |->
      o_nonline_at_offsets && o_line_rectangle && o_line_samples == 3'h4)
      else $error("on-pattern lines wrong");
   AST_OFFS_IGNORED: assert property (
      !o_nonline_at_offsets |-> o_sample_offsets == 32'h0) else $error("offsets leak");
   AST_PS_OFFS: assert property (
      o_ps_at_offsets |-> o_ps_per_sample && o_depth_at_offsets) else $error("ps offsets");
   AST_DEPTH_COUNT: assert property (
      o_depth_buffer_samples == o_merge_samples) else $error("depth count");
   AST_PS_MERGE: assert property (
      o_ps_per_sample |-> o_merge_samples == 3'h4) else $error("merge count");
   AST_DEPTH_POS: assert property (
      o_nonline_at_offsets == o_depth_at_offsets) else $error("depth position");
endmodule

bind multisample_mode_control ms_ctrl_monitor mon_u (
   .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_address(i_address), .i_read(i_read),
   .i_write(i_write), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
   .o_line_samples(o_line_samples), .o_nonline_at_offsets(o_nonline_at_offsets),
   .o_line_at_offsets(o_line_at_offsets), .o_line_legacy(o_line_legacy),
   .o_line_rectangle(o_line_rectangle), .o_ps_per_sample(o_ps_per_sample),
   .o_ps_at_offsets(o_ps_at_offsets), .o_merge_samples(o_merge_samples),
   .o_depth_at_offsets(o_depth_at_offsets),
   .o_depth_buffer_samples(o_depth_buffer_samples), .o_sample_offsets(o_sample_offsets)
);

// file: ms_cmd_streamer.sv
`timescale 1ns/100ps
// ****************************************
// Command streamer, bus master side
// ****************************************
module ms_cmd_streamer (
   input  wire         i_clk_sys,
   input  wire         i_waitrequest,
   input  wire  [31:0] i_readdata,
   output logic [4:0]  o_address,
   output logic        o_read,
   output logic        o_write,
   output logic [3:0]  o_byteenable,
   output logic [31:0] o_writedata
);
   initial begin
      o_address = 5'h00;
      o_read = 1'b0;
      o_write = 1'b0;
      o_byteenable = 4'hF;
      o_writedata = 32'h00000000;
   end
   // Held until waitrequest is sampled low; data inverted once released
   // Only the bench timeout ends a wait, so a hung slave cannot pass silently
   task automatic acc(input logic rd, input logic [4:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge i_clk_sys);
      o_address   <= a;
      o_writedata <= d;
      o_read      <= rd;
      o_write     <= !rd;
      @(posedge i_clk_sys);
      while (i_waitrequest !== 1'b0) begin
         @(posedge i_clk_sys);
      end
      q = i_readdata;
      o_read      <= 1'b0;
      o_write     <= 1'b0;
      o_writedata <= ~d;
   endtask
   // Flushes, surface clears, target counts and viewport fixes belong to the pipeline
   // beyond this block; send always writes a header and two dwords, whatever its length field
   task automatic send(input logic [7:0] op, input logic [7:0] len,
                       input logic [31:0] dw1, input logic [31:0] dw2);
      logic [31:0] q;
      acc(1'b0, 5'h00, {3'h3, 2'h3, 3'h1, op, 8'h00, len}, q);
      acc(1'b0, 5'h00, dw1, q);
      acc(1'b0, 5'h00, dw2, q);
   endtask
endmodule

// file: multisample_mode_control_tb.sv
`timescale 1ns/100ps
// ****************************************
// Self-checking bench
// ****************************************
module multisample_mode_control_tb;
   logic        i_clk_sys;
   logic        i_rst;
   wire  [4:0]  adr;
   wire  [3:0]  be;
   wire  [31:0] wd, o_readdata, o_sample_offsets;
   wire         rd, wr, o_waitrequest, o_nonline_at_offsets, o_line_at_offsets;
   wire         o_line_legacy, o_line_rectangle, o_ps_per_sample, o_ps_at_offsets;
   wire         o_depth_at_offsets, o_pixel_location, o_config_invalid, o_cmd_error;
   wire  [2:0]  o_raster_samples, o_line_samples, o_merge_samples, o_depth_buffer_samples;
   int          n_fail, n_tests, cyc;
   logic [31:0] lf, q, ofs;
   initial i_clk_sys = 1'b0;
   always #10 i_clk_sys = ~i_clk_sys;
   multisample_mode_control dut_u (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_address(adr),
      .i_read(rd), .i_write(wr), .i_byteenable(be), .i_writedata(wd),
      .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
      .o_raster_samples(o_raster_samples), .o_line_samples(o_line_samples),
      .o_nonline_at_offsets(o_nonline_at_offsets), .o_line_at_offsets(o_line_at_offsets),
      .o_line_legacy(o_line_legacy), .o_line_rectangle(o_line_rectangle),
      .o_ps_per_sample(o_ps_per_sample), .o_ps_at_offsets(o_ps_at_offsets),
      .o_merge_samples(o_merge_samples), .o_depth_at_offsets(o_depth_at_offsets),
      .o_depth_buffer_samples(o_depth_buffer_samples), .o_pixel_location(o_pixel_location),
      .o_sample_offsets(o_sample_offsets), .o_config_invalid(o_config_invalid),
      .o_cmd_error(o_cmd_error));
   ms_cmd_streamer cs_u (.i_clk_sys(i_clk_sys), .i_waitrequest(o_waitrequest),
      .i_readdata(o_readdata), .o_address(adr), .o_read(rd), .o_write(wr),
      .o_byteenable(be), .o_writedata(wd));
   function automatic logic [31:0] lfsr(logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // Sample n sits 2n columns off the centre and at most one row off, so distance grows
   function automatic logic [31:0] legal_offs(logic [31:0] r);
      logic [31:0] v;
      v = 32'h0;
      for (int n = 0; n < 4; n++) begin
         v[8*n+4 +: 4] = r[4+n] ? 4'(8 + 2*n) : 4'(8 - 2*n);
         v[8*n +: 4]   = r[8+n] ? 4'(8 + r[n]) : 4'(8 - r[n]);
      end
      return v;
   endfunction
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Model of the decode; invalid mixes are judged by the flag alone
   task automatic check(int m, int d, int c, int l, logic [31:0] o, logic er);
      logic p, f, inv;
      logic [20:0] e, g;
      p = 1'(m % 2);
      f = (c == 2);
      inv = (c == 1) || (c == 0 && (p || d == 0));
      e = {(p && f) ? 3'h4 : 3'h1, (m == 3) ? 3'h4 : 3'h1, p, m == 3, m < 2, m > 1,
           d != 0 && f, d != 0 && f && p, f ? 3'h4 : 3'h1, p, f ? 3'h4 : 3'h1, 1'(l), inv};
      repeat (2) @(posedge i_clk_sys);
      g = {o_raster_samples, o_line_samples, o_nonline_at_offsets, o_line_at_offsets,
           o_line_legacy, o_line_rectangle, o_ps_per_sample, o_ps_at_offsets,
           o_merge_samples, o_depth_at_offsets, o_depth_buffer_samples,
           o_pixel_location, o_config_invalid};
      chk("invalid", 32'(inv), 32'(o_config_invalid));
      chk("cmd_error", 32'(er), 32'(o_cmd_error));
      if (!inv) chk("decode", 32'(e), 32'(g));
      if (!inv) chk("offsets", p ? o : 32'h0, o_sample_offsets);
      cs_u.acc(1'b1, 5'h08, 32'h0, q);
      chk("status", {26'h0, er, inv, 3'(c), 1'(l)}, q);
      cs_u.acc(1'b1, 5'h10, 32'h0, q);
      if (!inv) chk("decode_reg", {19'h0, e[4:2], e[8:5], e[9], e[10], e[11], e[12],
                                   e[13], e[14]}, q);
   endtask
   always @(posedge i_clk_sys) begin
      cyc++;
      if (cyc == 8000) begin
         n_fail++;
         report_and_stop;
      end
   end
   initial begin
      i_rst = 1'b1;
      lf = 32'h00012593;
      repeat (10) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      check(0, 1, 0, 0, 32'h0, 1'b0);
      cs_u.acc(1'b1, 5'h14, 32'h0, q);
      chk("unmapped", 32'h0, q);
      cs_u.acc(1'b0, 5'h0C, 32'hFFFFFFFF, q);
      cs_u.acc(1'b1, 5'h0C, 32'h0, q);
      chk("offs_ro", 32'h0, q);
      // Every mode and dispatch; count codes 0 to 2 only, reserved code 1 included
      for (int m = 0; m < 4; m++) begin
         for (int d = 0; d < 2; d++) begin
            for (int c = 0; c < 3; c++) begin
               lf = lfsr(lf);
               ofs = legal_offs(lf);
               cs_u.acc(1'b0, 5'h04, {29'h0, 1'(d), 2'(m)}, q);
               cs_u.send(8'h0D, 8'h01, {26'h0, 1'b0, lf[9], 3'(c), 1'b0}, ofs);
               check(m, d, c, 32'(lf[9]), ofs, 1'b0);
            end
         end
      end
      // Wrong length, then wrong sub-opcode: state kept, error sticks
      cs_u.send(8'h0D, 8'h02, 32'h0, 32'h0);
      cs_u.acc(1'b0, 5'h00, 32'h0, q);
      check(3, 1, 2, 32'(lf[9]), ofs, 1'b1);
      cs_u.send(8'h0E, 8'h01, 32'h0, 32'h0);
      // Writing zero to the status word must leave the error flag alone
      cs_u.acc(1'b0, 5'h08, 32'h00000000, q);
      check(3, 1, 2, 32'(lf[9]), ofs, 1'b1);
      cs_u.acc(1'b0, 5'h08, 32'h00000020, q);
      check(3, 1, 2, 32'(lf[9]), ofs, 1'b0);
      report_and_stop;
   end
endmodule
